// ===== dv/slice_error_concealment_tb_top.sv
// Purpose: Self-checking bench for the slice concealment block.
// Assumes: Zero-wait APB slave; one picture of 200 macroblocks.
// Notes:   Register rows first, then slice sequences and error flags.
`timescale 1ns/1ns
`default_nettype none
module slice_error_concealment_tb_top;
  import slice_conceal_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r;} row_t;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, d, st;
  logic        pready, pslverr, cmd_valid, cmd_ready, mb_done, slice_end;
  logic [2:0]  errs;
  logic        direct_b, coloc_missing, decode_en, discard, fill_valid;
  logic        zero_mv, ref_nonexist, saw_discard;
  logic [4:0]  ref_sub_store;
  slice_cmd_t  cmd;
  fill_mb_t    fill_mb, first_fill, last_fill;
  mb_pos_t     running_mb_position;
  int          mismatches, n_checks, n_fill;
  row_t rows [6] = '{
    '{REG_CTRL,      32'h8000_0000, 32'h0000_0000},
    '{REG_PIC_SIZE,  32'h0000_00C8, 32'h0000_00C8},
    '{REG_REF_ENTRY, 32'h0000_0085, 32'h0000_0085},
    '{REG_RUN_POS,   32'h0000_0050, 32'h0000_0050},
    '{REG_STATUS,    32'hFFFF_FFFF, 32'h0000_0000},
    '{8'h14,         32'h0000_00FF, 32'h0000_0000}};

  slice_error_concealment uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .mb_done(mb_done), .slice_end(slice_end), .vlc_err(errs[0]),
    .data_err(errs[1]), .ptr_err(errs[2]), .direct_b(direct_b),
    .coloc_missing(coloc_missing), .decode_en(decode_en),
    .discard(discard), .fill_valid(fill_valid), .fill_mb(fill_mb),
    .zero_mv(zero_mv), .ref_nonexist(ref_nonexist),
    .ref_sub_store(ref_sub_store),
    .running_mb_position(running_mb_position));

  slice_source drv (.pclk(pclk), .cmd_ready(cmd_ready),
    .decode_en(decode_en), .discard(discard), .cmd_valid(cmd_valid),
    .cmd(cmd), .mb_done(mb_done), .slice_end(slice_end));

  // Clock at 20 MHz.
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Records every filled block; values are the ones launched before the edge.
  always @(posedge pclk) begin
    if (fill_valid === 1'b1) begin
      if (n_fill == 0) first_fill = fill_mb;
      last_fill = fill_mb;
      n_fill++;
    end
    if (discard === 1'b1) saw_discard = 1'b1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic slice(input mb_pos_t f, input logic fop, input logic sg,
                       input int n_mb, input int n_exp, input mb_pos_t p0,
                       input mb_pos_t p_end);
    slice_cmd_t c;
    c = '{f, fop, 5'h03, sg, 8'h02};
    n_fill = 0;
    drv.run_slice(c, n_mb);
    chk(32'(n_fill), 32'(n_exp));
    if (n_exp > 0) begin
      chk(32'(first_fill.pos), 32'(p0));
    end
    chk(32'(running_mb_position), 32'(p_end));
  endtask

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Whole run is a few hundred cycles, so this only trips on a hang.
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    conclude();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {errs, direct_b, coloc_missing, saw_discard} = '0;
    mismatches = 0;
    n_checks = 0;
    n_fill = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      apb(1'b0, 8'(4 * k), 32'h0000_0000, d);
      chk(d, 32'h0000_0000);
    end
    foreach (rows[k]) begin
      apb(1'b1, rows[k].a, rows[k].w, d);
      apb(1'b0, rows[k].a, 32'h0000_0000, d);
      chk(d, rows[k].r);
    end
    chk({ref_nonexist, ref_sub_store}, 32'h0000_0025);
    slice(16'h0000, 1'b1, 1'b0, 80, 0, 16'h0000, 16'h0050);
    slice(16'h0064, 1'b0, 1'b0, 10, 20, 16'h0050, 16'h006E);
    chk(last_fill.intra, 1'b1);
    apb(1'b1, REG_CTRL, 32'h0000_0305, d);
    fork
      slice(16'h0078, 1'b0, 1'b1, 5, 16, 16'h0068, 16'h007D);
      begin
        repeat (6) @(posedge pclk);
        apb(1'b0, REG_STATUS, 32'h0000_0000, st);
        chk(st[ST_FILL_BIT], 1'b1);
      end
    join
    chk({last_fill.intra, last_fill.store}, 32'h0000_0003);
    slice(16'h0076, 1'b0, 1'b0, 0, 0, 16'h0000, 16'h0076);
    chk(saw_discard, 1'b0);
    slice(16'h00FA, 1'b0, 1'b0, 0, 82, 16'h0076, 16'h00C8);
    chk({last_fill.pos, last_fill.store}, 32'h0018_E2);
    chk(saw_discard, 1'b1);
    apb(1'b0, REG_STATUS, 32'h0000_0000, d);
    chk(d, 32'h0000_0000);
    for (int k = 0; k < 3; k++) begin
      errs <= 3'(1 << k);
      @(posedge pclk);
      errs <= 3'b000;
      apb(1'b0, REG_STATUS, 32'h0000_0000, d);
      chk(d[ST_ERR_BIT], 1'b1);
      apb(1'b1, REG_CTRL, 32'h8000_0305, d);
      apb(1'b0, REG_STATUS, 32'h0000_0000, d);
      chk(d[ST_ERR_BIT], 1'b0);
    end
    for (int k = 0; k < 4; k++) begin
      direct_b <= k[0];
      coloc_missing <= k[1];
      @(negedge pclk);
      chk(zero_mv, k[0] & k[1]);
      @(posedge pclk);
    end
    // Mid-run reset must wipe the position and the stored picture size.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'(running_mb_position), 32'h0000_0000);
    presetn <= 1'b1;
    apb(1'b0, REG_PIC_SIZE, 32'h0000_0000, d);
    chk(d, 32'h0000_0000);
    chk(pslverr, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire

// ===== dv/slice_source.sv
// Purpose: Driver and reconstruction side of the slice interface.
// Assumes: A command is taken at an edge where cmd_ready is high.
// Notes:   Released command bits are inverted so stale data never helps.
`timescale 1ns/1ns
`default_nettype none
module slice_source (
  input  wire logic                     pclk,
  input  wire logic                     cmd_ready,
  input  wire logic                     decode_en,
  input  wire logic                     discard,
  output var logic                      cmd_valid,
  output slice_conceal_pkg::slice_cmd_t cmd,
  output var logic                      mb_done,
  output var logic                      slice_end
);
  import slice_conceal_pkg::*;

  // Idle levels before the first command.
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    mb_done = 1'b0;
    slice_end = 1'b0;
  end

  // One slice: command, decoded pulses, end pulse; a phantom sends zero pulses.
  task automatic run_slice(input slice_cmd_t c, input int n_mb);
    int w;
    @(posedge pclk);
    cmd_valid <= 1'b1;
    cmd       <= c;
    do @(negedge pclk); while (cmd_ready !== 1'b1);
    @(posedge pclk);
    cmd_valid <= 1'b0;
    cmd       <= ~c;
    w = 0;
    do begin
      @(negedge pclk);
      w++;
    end while (decode_en !== 1'b1 && discard !== 1'b1 && w < 400);
    for (int i = 0; i < n_mb; i++) begin
      @(posedge pclk);
      mb_done <= 1'b1;
      @(posedge pclk);
      mb_done <= 1'b0;
    end
    @(posedge pclk);
    slice_end <= 1'b1;
    @(posedge pclk);
    slice_end <= 1'b0;
    do @(negedge pclk); while (cmd_ready !== 1'b1);
  endtask
endmodule
`default_nettype wire

// ===== include/slice_conceal_pkg.sv
// Purpose: Shared constants, register map and types for the slice error
//          concealment block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes:   Positions are macroblock counts in raster order.
//
// What the block and its driver software must do
// R01 - Read-only flag shows that missing macroblocks are being filled.
// R02 - Read-only error flag raised by decode, decoded-data or pointer list error.
// R03 - Running macroblock position advances in hardware as macroblocks decode.
// R04 - Before each slice, compare running position with slice first position.
// R05 - Running position beyond slice start snaps back to the slice start.
// R06 - At picture end, remaining input data is discarded.
// R07 - Running position below slice start fills the gap, then decodes.
// R08 - Fill starts at running minus min(prior count, rewind times pairing factor).
// R09 - Intra mode with empty picture buffer conceals as 16x16 intra, DC chroma.
// R10 - Inter mode copies co-located blocks from the command's store, default list0 top.
// R11 - Driver sends phantom slice at or past picture size to fill to end.
// R12 - Picture size stored; decoding and filling stop at that boundary.
// R13 - Driver may load the running position directly.
// R14 - Direct B blocks use zero motion when co-located reference is missing.
// R15 - Pointer list entry: bit 7 non-existent, bits 4:0 substitute store.
// R16 - Software marks missing references non-existent with a replacement index.
// R17 - Stream switches happen only at picture boundaries.
// R18 - Detection and concealment act only at slice boundaries, no software control.
// R19 - First slice of a new picture clears the running position to zero.
// R20 - Phantom slice carries zero indirect data length.
// R21 - Fill flag set at fill start, cleared when fill target is reached.
package slice_conceal_pkg;

  localparam int unsigned MBW = 16;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_PIC_SIZE  = 8'h04;
  localparam logic [7:0] REG_RUN_POS   = 8'h08;
  localparam logic [7:0] REG_STATUS    = 8'h0C;
  localparam logic [7:0] REG_REF_ENTRY = 8'h10;

  // Control fields.
  localparam int unsigned CTRL_INTER_BIT  = 0;
  localparam int unsigned CTRL_DPB_BIT    = 1;
  localparam int unsigned CTRL_MBAFF_BIT  = 2;
  localparam int unsigned CTRL_REWIND_LSB = 8;
  localparam int unsigned REWIND_W        = 8;
  localparam int unsigned CTRL_ERRCLR_BIT = 31;

  // Status fields.
  localparam int unsigned ST_FILL_BIT    = 0;
  localparam int unsigned ST_ERR_BIT     = 1;
  localparam int unsigned ST_DISCARD_BIT = 2;

  // Reference pointer list entry layout.
  localparam int unsigned REF_NONEXIST_BIT = 7;
  localparam int unsigned REF_IDX_W        = 5;

  localparam logic [MBW-1:0] MB_ZERO   = 16'h0000;
  localparam logic [MBW-1:0] MB_ONE    = 16'h0001;
  localparam logic [31:0]    CTRL_RST  = 32'h0000_0000;
  localparam logic [MBW-1:0] SIZE_RST  = 16'h0000;

  typedef logic [MBW-1:0] mb_pos_t;

  // Slice command from the driver side.
  typedef struct packed {
    mb_pos_t                first_mb;
    logic                   first_of_pic;
    logic [REF_IDX_W-1:0]   conceal_store;
    logic                   store_given;
    logic [7:0]             list0_top;
  } slice_cmd_t;

  // Concealed macroblock handed to reconstruction.
  typedef struct packed {
    mb_pos_t                pos;
    logic                   intra;
    logic [REF_IDX_W-1:0]   store;
  } fill_mb_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_DECODE = 2'b01,
    ST_FILL   = 2'b11,
    ST_DRAIN  = 2'b10
  } seq_state_t;

  // Lower of two positions.
  function automatic mb_pos_t mb_min(input mb_pos_t a, input mb_pos_t b);
    mb_min = (a < b) ? a : b;
  endfunction

endpackage

// ===== logic/apb_regs.sv
// Purpose: APB slave holding control, picture size and the driver load of
//          the running position.
// Assumes: Zero wait states; unmapped reads return zero, pslverr low.
// Notes:   Running position write is a one-cycle load pulse.
`timescale 1ns/1ns
`default_nettype none
module apb_regs
  import slice_conceal_pkg::*;
(
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [31:0]                   status,
  input  wire slice_conceal_pkg::mb_pos_t    run_pos,
  output logic [31:0]                        ctrl,
  output slice_conceal_pkg::mb_pos_t         pic_size,
  output logic [7:0]                         ref_entry,
  output logic                               pos_load,
  output logic                               err_clear
);
  logic [31:0] ctrl_q, ctrl_d;
  mb_pos_t     size_q, size_d;
  logic [7:0]  ref_q, ref_d;
  logic        wr;

  assign wr      = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // Write decode and read mux.
  always_comb begin
    ctrl_d    = ctrl_q;
    size_d    = size_q;
    ref_d     = ref_q;
    pos_load  = 1'b0;
    err_clear = 1'b0;
    if (wr) begin
      case (paddr)
        REG_CTRL: begin
          ctrl_d    = pwdata;
          ctrl_d[CTRL_ERRCLR_BIT] = 1'b0;
          err_clear = pwdata[CTRL_ERRCLR_BIT];
        end
        REG_PIC_SIZE:  size_d   = pwdata[MBW-1:0];   // [R12]
        REG_RUN_POS:   pos_load = 1'b1;              // [R13]
        REG_REF_ENTRY: ref_d    = pwdata[7:0];
        default: ;
      endcase
    end
    case (paddr)
      REG_CTRL:      prdata = ctrl_q;
      REG_PIC_SIZE:  prdata = {16'h0000, size_q};
      REG_RUN_POS:   prdata = {16'h0000, run_pos};
      REG_STATUS:    prdata = status;
      REG_REF_ENTRY: prdata = {24'h000000, ref_q};
      default:       prdata = 32'h0000_0000;
    endcase
  end

  // Register storage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      size_q <= SIZE_RST;
      ref_q  <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      size_q <= size_d;
      ref_q  <= ref_d;
    end
  end

  assign ctrl      = ctrl_q;
  assign pic_size  = size_q;
  assign ref_entry = ref_q;
endmodule
`default_nettype wire

// ===== logic/ref_entry_decode.sv
// Purpose: Decodes one reference pointer list entry and the direct-mode
//          motion override.
// Assumes: Entry byte written by software.
// Notes:   Purely combinational.
`timescale 1ns/1ns
`default_nettype none
module ref_entry_decode
  import slice_conceal_pkg::*;
(
  input  wire logic [7:0]                             entry,
  input  wire logic                                   direct_b,
  input  wire logic                                   coloc_missing,
  output logic                                        nonexist,
  output logic [slice_conceal_pkg::REF_IDX_W-1:0]     sub_store,
  output logic                                        zero_mv
);
  // Entry fields and zero-motion choice for direct blocks.
  always_comb begin
    nonexist  = entry[REF_NONEXIST_BIT];          // [R15]
    sub_store = entry[REF_IDX_W-1:0];             // [R15]
    zero_mv   = direct_b & coloc_missing;         // [R14]
  end
endmodule
`default_nettype wire

// ===== logic/slice_error_concealment.sv
// Purpose: Slice-boundary error detection and macroblock gap concealment.
// Assumes: Slice commands and decoded-macroblock pulses come from logic on
//          pclk; error sources are same-clock pulses.
// Notes:   Checks happen only when a slice command is accepted, so the
//          filling runs without software involvement.
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module slice_error_concealment
  import slice_conceal_pkg::*;
(
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          cmd_valid,
  output logic                               cmd_ready,
  input  wire slice_conceal_pkg::slice_cmd_t cmd,
  input  wire logic                          mb_done,
  input  wire logic                          slice_end,
  input  wire logic                          vlc_err,
  input  wire logic                          data_err,
  input  wire logic                          ptr_err,
  input  wire logic                          direct_b,
  input  wire logic                          coloc_missing,
  output logic                               decode_en,
  output logic                               discard,
  output logic                               fill_valid,
  output slice_conceal_pkg::fill_mb_t        fill_mb,
  output logic                               zero_mv,
  output logic                               ref_nonexist,
  output logic [slice_conceal_pkg::REF_IDX_W-1:0] ref_sub_store,
  output slice_conceal_pkg::mb_pos_t         running_mb_position
);
  logic [31:0] ctrl;
  logic [31:0] status;
  mb_pos_t     pic_size;
  logic [7:0]  ref_entry;
  logic        pos_load;
  logic        err_clear;

  seq_state_t  state_q, state_d;
  mb_pos_t     pos_q, pos_d;
  mb_pos_t     target_q, target_d;
  mb_pos_t     count_q, count_d;
  mb_pos_t     prior_q, prior_d;
  logic        err_q, err_d;
  logic        inter_q, inter_d;
  logic [REF_IDX_W-1:0] store_q, store_d;
  fill_mb_t    fill_q, fill_d;
  logic        fvalid_q, fvalid_d;

  logic        inter_mode;
  logic        dpb_empty;
  mb_pos_t     rewind;
  mb_pos_t     back;
  mb_pos_t     start_pos;
  mb_pos_t     end_limit;

  apb_regs u_regs (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .status    (status),
    .run_pos   (pos_q),
    .ctrl      (ctrl),
    .pic_size  (pic_size),
    .ref_entry (ref_entry),
    .pos_load  (pos_load),
    .err_clear (err_clear)
  );

  ref_entry_decode u_ref (
    .entry         (ref_entry),
    .direct_b      (direct_b),
    .coloc_missing (coloc_missing),
    .nonexist      (ref_nonexist),
    .sub_store     (ref_sub_store),
    .zero_mv       (zero_mv)
  );

  // Rewind distance; paired frames rewind twice as far.
  always_comb begin
    inter_mode = ctrl[CTRL_INTER_BIT];
    dpb_empty  = ~ctrl[CTRL_DPB_BIT];
    rewind     = {{(MBW-REWIND_W){1'b0}},
                  ctrl[CTRL_REWIND_LSB +: REWIND_W]};
    if (ctrl[CTRL_MBAFF_BIT])
      rewind = {rewind[MBW-2:0], 1'b0};
    back       = mb_min(prior_q, rewind);                   // [R08]
    start_pos  = (pos_q > back) ? (pos_q - back) : MB_ZERO; // [R08]
    end_limit  = mb_min(cmd.first_mb, pic_size);            // [R12]
  end

  // Sequencer: slice-boundary check, gap fill and decode tracking.
  always_comb begin
    state_d  = state_q;
    pos_d    = pos_q;
    target_d = target_q;
    count_d  = count_q;
    prior_d  = prior_q;
    inter_d  = inter_q;
    store_d  = store_q;
    fill_d   = fill_q;
    fvalid_d = 1'b0;
    cmd_ready = 1'b0;
    case (state_q)
      ST_IDLE: begin
        cmd_ready = 1'b1;                                   // [R18]
        if (cmd_valid) begin
          inter_d = inter_mode;
          store_d = cmd.store_given ? cmd.conceal_store     // [R10]
                                    : cmd.list0_top[REF_IDX_W-1:0];
          if (cmd.first_of_pic) begin
            pos_d   = MB_ZERO;                              // [R19]
            // A new picture drops all per-picture history, so a stream
            // switch is only clean here and never inside a picture.
            prior_d = MB_ZERO;                              // [R17]
          end
          count_d = MB_ZERO;
          if ((cmd.first_of_pic ? MB_ZERO : pos_q) == cmd.first_mb) begin
            state_d = (cmd.first_mb >= pic_size) ? ST_DRAIN // [R04]
                                                 : ST_DECODE;
          end else if (!cmd.first_of_pic && pos_q > cmd.first_mb) begin
            pos_d   = cmd.first_mb;                         // [R05]
            state_d = (cmd.first_mb >= pic_size) ? ST_DRAIN : ST_DECODE;
          end else if (cmd.first_of_pic) begin
            target_d = end_limit;                           // [R07]
            state_d  = ST_FILL;                             // [R21]
          end else begin
            pos_d    = start_pos;                           // [R08]
            target_d = end_limit;                           // [R07]
            state_d  = ST_FILL;                             // [R21]
          end
        end
      end
      ST_FILL: begin
        if (pos_q >= target_q || pos_q >= pic_size) begin   // [R12]
          state_d = (pos_q >= pic_size) ? ST_DRAIN : ST_DECODE; // [R21]
        end else begin
          fvalid_d     = 1'b1;
          fill_d.pos   = pos_q;
          fill_d.intra = ~inter_q & dpb_empty;              // [R09]
          fill_d.store = store_q;                           // [R10]
          pos_d        = pos_q + MB_ONE;
        end
      end
      ST_DECODE: begin
        if (pos_q >= pic_size) begin
          state_d = ST_DRAIN;                               // [R12]
        end else if (mb_done) begin
          pos_d   = pos_q + MB_ONE;                         // [R03]
          count_d = count_q + MB_ONE;
        end
        if (slice_end && pos_q < pic_size) begin
          prior_d = mb_done ? count_q + MB_ONE : count_q;
          state_d = ST_IDLE;
        end
      end
      ST_DRAIN: begin
        // Input left over past picture end is swallowed until slice end.
        if (slice_end) begin                                // [R06]
          prior_d = count_q;
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (pos_load)
      pos_d = pwdata[MBW-1:0];                              // [R13]
  end

  // Sticky slice error; a new error wins over a software clear.
  always_comb begin
    err_d = err_q;
    if (err_clear)
      err_d = 1'b0;
    if (vlc_err | data_err | ptr_err)
      err_d = 1'b1;                                         // [R02]
  end

  // State registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= ST_IDLE;
      pos_q    <= MB_ZERO;
      target_q <= MB_ZERO;
      count_q  <= MB_ZERO;
      prior_q  <= MB_ZERO;
      err_q    <= 1'b0;
      inter_q  <= 1'b0;
      store_q  <= '0;
      fill_q   <= '0;
      fvalid_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      pos_q    <= pos_d;
      target_q <= target_d;
      count_q  <= count_d;
      prior_q  <= prior_d;
      err_q    <= err_d;
      inter_q  <= inter_d;
      store_q  <= store_d;
      fill_q   <= fill_d;
      fvalid_q <= fvalid_d;
    end
  end

  // Status word and outputs toward the pipeline.
  always_comb begin
    status = 32'h0000_0000;
    status[ST_FILL_BIT]    = (state_q == ST_FILL);          // [R01]
    status[ST_ERR_BIT]     = err_q;                         // [R02]
    status[ST_DISCARD_BIT] = (state_q == ST_DRAIN);
  end
  assign decode_en           = (state_q == ST_DECODE);
  assign discard             = (state_q == ST_DRAIN);       // [R06]
  assign fill_valid          = fvalid_q;
  assign fill_mb             = fill_q;
  assign running_mb_position = pos_q;

  // Checks on the sequencer, the error flag and the zero-motion override.
  property p_fill_flag;
    @(posedge pclk) disable iff (!presetn)
      (state_q == ST_IDLE && cmd_valid && !cmd.first_of_pic &&
       pos_q < cmd.first_mb && pos_q < pic_size && !pos_load)
      |=> status[ST_FILL_BIT];
  endproperty
  a_fill_flag: assert property (p_fill_flag) // [R21]
    else $error("Fill flag not raised on gap.");

  property p_snap_back;
    @(posedge pclk) disable iff (!presetn)
      (state_q == ST_IDLE && cmd_valid && !cmd.first_of_pic &&
       pos_q > cmd.first_mb && !pos_load) |=> pos_q == $past(cmd.first_mb);
  endproperty
  a_snap_back: assert property (p_snap_back) // [R05]
    else $error("Position not snapped to slice start.");

  property p_new_pic;
    @(posedge pclk) disable iff (!presetn)
      (state_q == ST_IDLE && cmd_valid && cmd.first_of_pic && !pos_load)
      |=> pos_q == MB_ZERO;
  endproperty
  a_new_pic: assert property (p_new_pic) // [R19]
    else $error("Position not cleared at new picture.");

  property p_err_sticky;
    @(posedge pclk) disable iff (!presetn)
      (vlc_err | data_err | ptr_err) |=> status[ST_ERR_BIT];
  endproperty
  a_err_sticky: assert property (p_err_sticky) // [R02]
    else $error("Slice error flag missed an error.");

  property p_no_overrun;
    @(posedge pclk) disable iff (!presetn)
      fill_valid |-> fill_mb.pos < pic_size;
  endproperty
  a_no_overrun: assert property (p_no_overrun) // [R12]
    else $error("Fill past picture size.");

  sequence s_fill_step;
    state_q == ST_FILL && pos_q < target_q && pos_q < pic_size && !pos_load;
  endsequence
  property p_fill_step;
    @(posedge pclk) disable iff (!presetn)
      s_fill_step |=> fill_valid && pos_q == $past(pos_q) + MB_ONE;
  endproperty
  a_fill_step: assert property (p_fill_step) // [R07]
    else $error("Fill did not advance.");

  property p_mb_count;
    @(posedge pclk) disable iff (!presetn)
      (state_q == ST_DECODE && mb_done && pos_q < pic_size && !pos_load)
      |=> pos_q == $past(pos_q) + MB_ONE;
  endproperty
  a_mb_count: assert property (p_mb_count) // [R03]
    else $error("Running position did not advance.");

  property p_load;
    @(posedge pclk) disable iff (!presetn)
      pos_load |=> pos_q == $past(pwdata[MBW-1:0]);
  endproperty
  a_load: assert property (p_load) // [R13]
    else $error("Driver load of position lost.");

  property p_zero_mv;
    @(posedge pclk) disable iff (!presetn)
      (direct_b && coloc_missing) |-> zero_mv;
  endproperty
  a_zero_mv: assert property (p_zero_mv) // [R14]
    else $error("Zero motion not forced.");
endmodule
`default_nettype wire
